// >>> verilog/twcb_pkg.sv
package twcb_pkg;
  // Register indices; byte address is four times the index.
  localparam logic [5:0] TWCB_IDX_TIMER_INTERRUPT_CONTROL    = 6'h01;
  localparam logic [5:0] TWCB_IDX_DIR     = 6'h06;
  localparam logic [5:0] TWCB_IDX_PWMHI   = 6'h07;
  localparam logic [5:0] TWCB_IDX_PWMCNT  = 6'h08;
  localparam logic [5:0] TWCB_IDX_PWMPRD  = 6'h09;
  localparam logic [5:0] TWCB_IDX_PWMDTY  = 6'h0A;
  localparam logic [5:0] TWCB_IDX_PDN     = 6'h0B;
  localparam logic [5:0] TWCB_IDX_ODN     = 6'h0C;
  localparam logic [5:0] TWCB_IDX_PHI     = 6'h0D;
  localparam logic [5:0] TWCB_IDX_WDOG    = 6'h0E;
  localparam logic [5:0] TWCB_IDX_MASK    = 6'h0F;
  localparam logic [5:0] TWCB_IDX_COUNTER = 6'h11;
  localparam logic [5:0] TWCB_IDX_PORT    = 6'h16;
  localparam logic [5:0] TWCB_IDX_STATUS  = 6'h1F;

  // Field positions in the timer control register.
  localparam int TWCB_TIMER_INTERRUPT_CONTROL_EDGE = 7;
  localparam int TWCB_TIMER_INTERRUPT_CONTROL_GIE  = 6;
  localparam int TWCB_TIMER_INTERRUPT_CONTROL_SRC  = 5;
  localparam int TWCB_TIMER_INTERRUPT_CONTROL_TEDG = 4;
  localparam int TWCB_TIMER_INTERRUPT_CONTROL_PSE  = 3;
  // Field positions in the watchdog control register.
  localparam int TWCB_WD_EN   = 7;
  localparam int TWCB_WD_EIS  = 6;
  localparam int TWCB_WD_PSE  = 5;
  localparam int TWCB_WD_R_HI = 4;
  localparam int TWCB_WD_R_LO = 2;
  // Interrupt source positions.
  localparam int TWCB_IRQ_PWM = 4;
  localparam int TWCB_IRQ_CMP = 3;
  localparam int TWCB_IRQ_EXT = 2;
  localparam int TWCB_IRQ_CHG = 1;
  localparam int TWCB_IRQ_OVF = 0;
  // Pin assignments.
  localparam int TWCB_PIN_EXT = 0;
  localparam int TWCB_PIN_PWM = 1;
  localparam int TWCB_PIN_TMR = 2;

  // Writable-bit masks; other bits read as zero, except timer control bit 6 (global enable) and PWM high bits 5:4 (PWM count bits 9:8).
  localparam logic [7:0] TWCB_MASK_TIMER_INTERRUPT_CONTROL = 8'hBF;
  localparam logic [7:0] TWCB_MASK_PDN  = 8'h70;
  localparam logic [7:0] TWCB_MASK_ODN  = 8'hF7;
  localparam logic [7:0] TWCB_MASK_WDOG = 8'hFC;
  localparam logic [7:0] TWCB_MASK_IRQ  = 8'h1F;
  localparam logic [7:0] TWCB_MASK_PWMH = 8'h0F;

  // Reset values.
  localparam logic [7:0] TWCB_RST_TIMER_INTERRUPT_CONTROL = 8'hBF;
  localparam logic [7:0] TWCB_RST_DIR  = 8'hFF;
  localparam logic [7:0] TWCB_RST_PDN  = 8'h70;
  localparam logic [7:0] TWCB_RST_ODN  = 8'h00;
  localparam logic [7:0] TWCB_RST_PHI  = 8'hF7;
  localparam logic [7:0] TWCB_RST_WDOG = 8'h80;
  localparam logic [7:0] TWCB_RST_ZERO = 8'h00;
  localparam logic [7:0] TWCB_BYTE_MAX = 8'hFF;

  // Watchdog time-out: figure in microseconds, oscillator rate in kHz.
  localparam int TWCB_WDT_TIMEOUT_US = 18000;
  localparam int TWCB_RC_KHZ         = 128;
  localparam int TWCB_WDT_TICKS      = TWCB_WDT_TIMEOUT_US * TWCB_RC_KHZ / 1000;
endpackage : twcb_pkg

// >>> verilog/twcb_sync.sv
`timescale 1ns/1ns
module twcb_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             core_clk,  // System clock.
  input  wire logic             reset_n,   // Asynchronous reset.
  input  wire logic [WIDTH-1:0] async_in,  // Raw pin levels.
  output logic      [WIDTH-1:0] sync_out   // Two-stage synchronised levels.
);
  logic [WIDTH-1:0] meta_reg;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule : twcb_sync

// >>> verilog/twcb_prescaler.sv
`timescale 1ns/1ns
module twcb_prescaler (
  input  wire logic       core_clk,  // System clock.
  input  wire logic       reset_n,   // Asynchronous reset.
  input  wire logic       tick_in,   // Undivided count event.
  input  wire logic       enable,    // Division on; off gives 1:1.
  input  wire logic [2:0] ratio,     // Code n divides by two to the n+1.
  input  wire logic       clear,     // Clears the divider count.
  output logic            tick_out   // Divided count event.
);
  logic [7:0] count_reg;
  logic [7:0] ratio_mask;

  // Code 0 needs one bit of the count, code 7 all eight.
  assign ratio_mask = 8'((9'h002 << ratio) - 9'h001);
  assign tick_out   = tick_in && (!enable || ((count_reg & ratio_mask) == ratio_mask));

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      count_reg <= 8'h00;
    end else if (clear) begin
      count_reg <= 8'h00;
    end else if (tick_in && enable) begin
      count_reg <= count_reg + 8'h01;
    end
  end

  chk_psc_clear: assert property (@(posedge core_clk) disable iff (!reset_n)
    clear |=> count_reg == 8'h00) else $error("prescaler count not cleared");
endmodule : twcb_prescaler

// >>> verilog/twcb_bank.sv
// Our own choices: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ns
module twcb_bank
  import twcb_pkg::*;
#(
  parameter int WDT_TIMEOUT_TICKS = twcb_pkg::TWCB_WDT_TICKS
) (
  input  wire logic        core_clk,        // 100 MHz instruction clock.
  input  wire logic        reset_n,         // Asynchronous reset, active low.
  input  wire logic [7:0]  address,         // Avalon byte address.
  input  wire logic        read,            // Avalon read request.
  input  wire logic        write,           // Avalon write request.
  input  wire logic [31:0] writedata,       // Avalon write data.
  output logic      [31:0] readdata,        // Avalon read data.
  output logic             waitrequest,     // Avalon wait request.
  input  wire logic        instr_disable,   // Disable-interrupts instruction pulse.
  input  wire logic        instr_enable,    // Enable-interrupts instruction pulse.
  input  wire logic        instr_return,    // Return-from-interrupt instruction pulse.
  input  wire logic        instr_wdog_clr,  // Watchdog-clear instruction pulse.
  input  wire logic        instr_sleep,     // Sleep instruction pulse.
  input  wire logic        irq_taken,       // Core has taken an interrupt.
  input  wire logic        cmp_event,       // Comparator output change pulse.
  input  wire logic        change_event,    // Port input change pulse.
  input  wire logic        wdog_osc,        // Watchdog RC oscillator, asynchronous.
  input  wire logic [7:0]  port_in,         // Port pin levels.
  output logic      [7:0]  port_out,        // Port pin drive values.
  output logic      [7:0]  port_oe,         // Port pin drive enables.
  output logic      [2:0]  pulldown_n,      // Pull-down enables, active low.
  output logic      [7:0]  pullhigh_n,      // Pull-high enables, active low.
  output logic      [7:0]  opendrain,       // Open-drain enables.
  output logic             pwm_out,         // PWM waveform.
  output logic             irq_request,     // Masked, globally enabled request.
  output logic             wdog_reset       // Watchdog time-out reset pulse.
);
  import twcb_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // Register storage and pin synchronisers.
  logic [7:0] timer_interrupt_control_reg, dir_reg, pdn_reg, odn_reg, phi_reg, wdog_reg, mask_reg;
  logic [7:0] counter_reg, port_data_reg, pend_reg;
  logic [9:0] period_reg, duty_reg, pwm_cnt_reg;
  logic [15:0] wdog_cnt_reg;
  logic [7:0] pins_sync;
  logic       osc_sync, osc_prev_reg, pin_tmr_prev_reg, pin_ext_prev_reg;
  logic       wait_reg;

  twcb_sync #(.WIDTH(9)) u_sync (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .async_in ({wdog_osc, port_in}),
    .sync_out ({osc_sync, pins_sync})
  );

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      osc_prev_reg     <= 1'b0;
      pin_tmr_prev_reg <= 1'b0;
      pin_ext_prev_reg <= 1'b0;
    end else begin
      osc_prev_reg     <= osc_sync;
      pin_tmr_prev_reg <= pins_sync[TWCB_PIN_TMR];
      pin_ext_prev_reg <= pins_sync[TWCB_PIN_EXT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Avalon slave: one wait state, then the access completes.
  logic [5:0] reg_idx;
  logic       wr_do, rd_cap;
  logic [7:0] wr_byte, rd_byte;

  assign reg_idx = address[7:2];
  assign wr_byte = writedata[7:0];
  assign wr_do   = write && !wait_reg;
  assign rd_cap  = read && wait_reg;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      wait_reg <= 1'b1;
    end else begin
      wait_reg <= !((read || write) && wait_reg);
    end
  end
  assign waitrequest = wait_reg;

  always_comb begin
    rd_byte = TWCB_RST_ZERO;
    unique case (reg_idx)
      TWCB_IDX_TIMER_INTERRUPT_CONTROL:    rd_byte = timer_interrupt_control_reg;
      TWCB_IDX_DIR:     rd_byte = dir_reg;
      TWCB_IDX_PWMHI:   rd_byte = {2'b00, pwm_cnt_reg[9:8], period_reg[9:8], duty_reg[9:8]};
      TWCB_IDX_PWMCNT:  rd_byte = pwm_cnt_reg[7:0];
      TWCB_IDX_PWMPRD:  rd_byte = period_reg[7:0];
      TWCB_IDX_PWMDTY:  rd_byte = duty_reg[7:0];
      TWCB_IDX_PDN:     rd_byte = pdn_reg;
      TWCB_IDX_ODN:     rd_byte = odn_reg;
      TWCB_IDX_PHI:     rd_byte = phi_reg;
      TWCB_IDX_WDOG:    rd_byte = wdog_reg;
      TWCB_IDX_MASK:    rd_byte = mask_reg;
      TWCB_IDX_COUNTER: rd_byte = counter_reg;
      TWCB_IDX_PORT:    rd_byte = pins_sync;
      TWCB_IDX_STATUS:  rd_byte = pend_reg & mask_reg;
      default:          rd_byte = TWCB_RST_ZERO;
    endcase
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      readdata <= 32'h0000_0000;
    end else if (rd_cap) begin
      readdata <= {24'h00_0000, rd_byte};
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Software-written configuration.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      dir_reg       <= TWCB_RST_DIR;
      pdn_reg       <= TWCB_RST_PDN;
      odn_reg       <= TWCB_RST_ODN;
      phi_reg       <= TWCB_RST_PHI;
      wdog_reg      <= TWCB_RST_WDOG;
      mask_reg      <= TWCB_RST_ZERO;
      port_data_reg <= TWCB_RST_ZERO;
      period_reg    <= 10'h000;
      duty_reg      <= 10'h000;
    end else if (wr_do) begin
      unique case (reg_idx)
        TWCB_IDX_DIR:    dir_reg <= wr_byte;
        TWCB_IDX_PDN:    pdn_reg <= wr_byte & TWCB_MASK_PDN;
        TWCB_IDX_ODN:    odn_reg <= wr_byte & TWCB_MASK_ODN;
        TWCB_IDX_PHI:    phi_reg <= wr_byte & TWCB_MASK_ODN;
        TWCB_IDX_WDOG:   wdog_reg <= wr_byte & TWCB_MASK_WDOG;
        TWCB_IDX_MASK:   mask_reg <= wr_byte & TWCB_MASK_IRQ;
        TWCB_IDX_PORT:   port_data_reg <= wr_byte;
        TWCB_IDX_PWMPRD: period_reg[7:0] <= wr_byte;
        TWCB_IDX_PWMDTY: duty_reg[7:0] <= wr_byte;
        TWCB_IDX_PWMHI: begin
          period_reg[9:8] <= wr_byte[3:2];
          duty_reg[9:8]   <= wr_byte[1:0];
        end
        default: ;
      endcase
    end
  end

  // Bit 6 of the timer control register belongs to the instruction stream and to interrupt entry only.
  logic gie_clr, gie_set;
  assign gie_clr = instr_disable || irq_taken;
  assign gie_set = instr_enable || instr_return;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      timer_interrupt_control_reg <= TWCB_RST_TIMER_INTERRUPT_CONTROL;
    end else begin
      if (wr_do && reg_idx == TWCB_IDX_TIMER_INTERRUPT_CONTROL) begin
        timer_interrupt_control_reg[7:0] <= {wr_byte[7], timer_interrupt_control_reg[TWCB_TIMER_INTERRUPT_CONTROL_GIE], wr_byte[5:0]} & 8'hFF;
      end
      if (gie_set) begin
        timer_interrupt_control_reg[TWCB_TIMER_INTERRUPT_CONTROL_GIE] <= 1'b1;
      end else if (gie_clr) begin
        timer_interrupt_control_reg[TWCB_TIMER_INTERRUPT_CONTROL_GIE] <= 1'b0;
      end
    end
  end

  chk_gie_clear: assert property (@(posedge core_clk) disable iff (!reset_n)
    gie_clr && !gie_set |=> !timer_interrupt_control_reg[TWCB_TIMER_INTERRUPT_CONTROL_GIE]) else $error("global enable not cleared");
  chk_gie_set: assert property (@(posedge core_clk) disable iff (!reset_n)
    gie_set |=> timer_interrupt_control_reg[TWCB_TIMER_INTERRUPT_CONTROL_GIE] [*1]) else $error("global enable not set");

  ////////////////////////////////////////////////////////////////////////////////
  // Eight-bit timer with its prescaler.
  logic tmr_rise, tmr_fall, tmr_src_tick, tmr_tick, ctr_write, ovf_event;

  assign tmr_rise  = pins_sync[TWCB_PIN_TMR] && !pin_tmr_prev_reg;
  assign tmr_fall  = !pins_sync[TWCB_PIN_TMR] && pin_tmr_prev_reg;
  // Edges closer than one clock apart are lost; the source must hold each level.
  assign tmr_src_tick = timer_interrupt_control_reg[TWCB_TIMER_INTERRUPT_CONTROL_SRC] ?
                        (timer_interrupt_control_reg[TWCB_TIMER_INTERRUPT_CONTROL_TEDG] ? tmr_fall : tmr_rise) : 1'b1;
  assign ctr_write = wr_do && reg_idx == TWCB_IDX_COUNTER;
  assign ovf_event = tmr_tick && !ctr_write && counter_reg == TWCB_BYTE_MAX;

  twcb_prescaler u_tmr_psc (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .tick_in  (tmr_src_tick),
    .enable   (timer_interrupt_control_reg[TWCB_TIMER_INTERRUPT_CONTROL_PSE]),
    .ratio    (timer_interrupt_control_reg[2:0]),
    .clear    (ctr_write),
    .tick_out (tmr_tick)
  );

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      counter_reg <= TWCB_RST_ZERO;
    end else if (ctr_write) begin
      counter_reg <= wr_byte;
    end else if (tmr_tick) begin
      counter_reg <= counter_reg + 8'h01;
    end
  end

  chk_tmr_count: assert property (@(posedge core_clk) disable iff (!reset_n)
    tmr_tick && !ctr_write |=> counter_reg == 8'($past(counter_reg) + 8'h01)) else $error("timer step wrong");
  chk_tmr_psc: assert property (@(posedge core_clk) disable iff (!reset_n)
    !timer_interrupt_control_reg[TWCB_TIMER_INTERRUPT_CONTROL_PSE] && !timer_interrupt_control_reg[TWCB_TIMER_INTERRUPT_CONTROL_SRC] |-> tmr_tick) else $error("1:1 rate missed a tick");

  ////////////////////////////////////////////////////////////////////////////////
  // External interrupt pin and pending flags; a set beats a same-cycle clear.
  logic       ext_rise, ext_fall, ext_event, pwm_event;
  logic [7:0] pend_set, pend_clr;

  assign ext_rise  = pins_sync[TWCB_PIN_EXT] && !pin_ext_prev_reg;
  assign ext_fall  = !pins_sync[TWCB_PIN_EXT] && pin_ext_prev_reg;
  assign ext_event = wdog_reg[TWCB_WD_EIS] &&
                     (timer_interrupt_control_reg[TWCB_TIMER_INTERRUPT_CONTROL_EDGE] ? ext_fall : ext_rise);
  assign pwm_event = pwm_cnt_reg == period_reg;

  always_comb begin
    pend_set = 8'h00;
    pend_set[TWCB_IRQ_OVF] = ovf_event;
    pend_set[TWCB_IRQ_CHG] = change_event;
    pend_set[TWCB_IRQ_EXT] = ext_event;
    pend_set[TWCB_IRQ_CMP] = cmp_event;
    pend_set[TWCB_IRQ_PWM] = pwm_event;
    // Software clears a flag by writing 0 to it; writing 1 leaves it alone.
    pend_clr = (wr_do && reg_idx == TWCB_IDX_STATUS) ? ~wr_byte : 8'h00;
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pend_reg <= TWCB_RST_ZERO;
    end else begin
      pend_reg <= ((pend_reg & ~pend_clr) | pend_set) & TWCB_MASK_IRQ;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_request <= 1'b0;
    end else begin
      irq_request <= timer_interrupt_control_reg[TWCB_TIMER_INTERRUPT_CONTROL_GIE] && |(pend_reg & mask_reg);
    end
  end

  chk_ovf_pending: assert property (@(posedge core_clk) disable iff (!reset_n)
    ovf_event |=> pend_reg[TWCB_IRQ_OVF] && counter_reg == 8'h00) else $error("overflow not flagged");
  chk_ext_edge: assert property (@(posedge core_clk) disable iff (!reset_n)
    wdog_reg[TWCB_WD_EIS] && !timer_interrupt_control_reg[TWCB_TIMER_INTERRUPT_CONTROL_EDGE] && ext_rise |=> pend_reg[TWCB_IRQ_EXT])
    else $error("rising edge missed");
  chk_status_read: assert property (@(posedge core_clk) disable iff (!reset_n)
    $past(rd_cap) && $past(reg_idx) == TWCB_IDX_STATUS |-> readdata[7:0] == $past(pend_reg & mask_reg))
    else $error("status read not masked");

  ////////////////////////////////////////////////////////////////////////////////
  // PWM timer: counts to the period, output high until the duty match.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pwm_cnt_reg <= 10'h000;
      pwm_out     <= 1'b1;
    end else begin
      pwm_cnt_reg <= pwm_event ? 10'h000 : pwm_cnt_reg + 10'h001;
      if (pwm_cnt_reg == duty_reg) begin
        pwm_out <= 1'b0;
      end else if (pwm_event) begin
        pwm_out <= 1'b1;
      end
    end
  end

  chk_pwm_match: assert property (@(posedge core_clk) disable iff (!reset_n)
    pwm_cnt_reg == duty_reg |=> !pwm_out) else $error("PWM high past duty match");

  ////////////////////////////////////////////////////////////////////////////////
  // Watchdog: ticks from its own oscillator, so it keeps counting in sleep.
  logic osc_tick, wdog_tick, wdog_clr, wdog_expire;

  assign osc_tick    = osc_sync && !osc_prev_reg;
  assign wdog_clr    = instr_wdog_clr || instr_sleep;
  assign wdog_expire = wdog_reg[TWCB_WD_EN] && wdog_tick &&
                       wdog_cnt_reg == 16'(WDT_TIMEOUT_TICKS - 1);

  twcb_prescaler u_wdog_psc (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .tick_in  (osc_tick),
    .enable   (wdog_reg[TWCB_WD_PSE]),
    .ratio    (wdog_reg[TWCB_WD_R_HI:TWCB_WD_R_LO]),
    .clear    (wdog_clr),
    .tick_out (wdog_tick)
  );

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      wdog_cnt_reg <= 16'h0000;
      wdog_reset   <= 1'b0;
    end else begin
      wdog_reset <= wdog_expire && !wdog_clr;
      if (wdog_clr || wdog_expire || !wdog_reg[TWCB_WD_EN]) begin
        wdog_cnt_reg <= 16'h0000;
      end else if (wdog_tick) begin
        wdog_cnt_reg <= wdog_cnt_reg + 16'h0001;
      end
    end
  end

  chk_wdog_clear: assert property (@(posedge core_clk) disable iff (!reset_n)
    wdog_clr |=> wdog_cnt_reg == 16'h0000 && !wdog_reset) else $error("watchdog not cleared");
  chk_wdog_expire: assert property (@(posedge core_clk) disable iff (!reset_n)
    wdog_expire && !wdog_clr |=> wdog_reset ##1 !wdog_reset) else $error("time-out reset wrong");

  ////////////////////////////////////////////////////////////////////////////////
  // Pad controls, registered so every output leaves a flip-flop.
  logic [7:0] oe_next;

  always_comb begin
    oe_next = ~dir_reg;
    for (int i = 0; i < 8; i++) begin
      if (odn_reg[i] && port_data_reg[i]) begin
        oe_next[i] = 1'b0;
      end
    end
    if (timer_interrupt_control_reg[TWCB_TIMER_INTERRUPT_CONTROL_SRC]) begin
      oe_next[TWCB_PIN_TMR] = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      port_out   <= TWCB_RST_ZERO;
      port_oe    <= TWCB_RST_ZERO;
      pulldown_n <= TWCB_RST_PDN[6:4];
      pullhigh_n <= TWCB_RST_PHI;
      opendrain  <= TWCB_RST_ODN;
    end else begin
      port_out   <= port_data_reg;
      port_oe    <= oe_next;
      pulldown_n <= pdn_reg[6:4];
      pullhigh_n <= phi_reg;
      opendrain  <= odn_reg;
    end
  end

  chk_dir_input: assert property (@(posedge core_clk) disable iff (!reset_n)
    (port_oe & $past(dir_reg)) == 8'h00) else $error("input pin driven");
endmodule : twcb_bank

// >>> tb/twcb_core_model.sv
`timescale 1ns/1ns
module twcb_core_model (
  input  wire logic        core_clk,     // Clock.
  input  wire logic [31:0] readdata,     // Read data.
  input  wire logic        waitrequest,  // Wait request.
  output logic      [7:0]  address,      // Byte address.
  output logic             read,         // Read request.
  output logic             write,        // Write request.
  output logic      [31:0] writedata     // Write data.
);
  initial begin
    address = 8'h00;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h0;
  end
  //////////////////////////////////////////////////////////////////////
  // The request waits for an edge first so that a back-to-back call never
  // raises a strobe in the time step where the last call lowered it.
  task automatic xfer(input logic wr, input logic [5:0] idx, input logic [7:0] wd,
                      output logic [7:0] rd);
    @(posedge core_clk);
    address <= {idx, 2'b00};
    read <= !wr;
    write <= wr;
    writedata <= {24'h0, wd};
    @(posedge core_clk);
    // Only the bench watchdog ends a wait that never gets its answer.
    while (waitrequest !== 1'b0) begin
      @(posedge core_clk);
    end
    rd = readdata[7:0];
    read <= 1'b0;
    write <= 1'b0;
  endtask : xfer
endmodule : twcb_core_model

// >>> tb/tb.sv
`timescale 1ns/1ns
module tb;
  import twcb_pkg::*;
  typedef struct {logic [5:0] i; logic [7:0] r, w, e;} twcb_row_t;
  logic        core_clk = 0, reset_n = 0, read, write, waitrequest, wdog_osc = 0;
  logic        instr_enable = 0, instr_disable = 0, instr_wdog_clr = 0, instr_sleep = 0, irq_taken = 0;
  logic [7:0]  pins = 8'h00;
  logic        pwm_out, irq_request, wdog_reset;
  logic [7:0]  address, port_out, port_oe, pullhigh_n, opendrain, rd, a;
  logic [2:0]  pulldown_n;
  logic [31:0] readdata, writedata;
  int          errors = 0, samples_checked = 0, hits = 0, h0 = 0, hi = 0;
  twcb_row_t   rows [11] = '{'{6'h01, 8'hBF, 8'h80, 8'h80}, '{6'h06, 8'hFF, 8'h5A, 8'h5A},
    '{6'h0B, 8'h70, 8'hFF, 8'h70}, '{6'h0C, 8'h00, 8'hFF, 8'hF7}, '{6'h0D, 8'hF7, 8'hFF, 8'hF7},
    '{6'h0E, 8'h80, 8'h7F, 8'h7C}, '{6'h0F, 8'h00, 8'hFF, 8'h1F}, '{6'h02, 8'h00, 8'hFF, 8'h00},
    '{6'h07, 8'h00, 8'hF0, 8'h00}, '{6'h09, 8'h00, 8'h03, 8'h03}, '{6'h0A, 8'h00, 8'h01, 8'h01}};
  twcb_bank #(.WDT_TIMEOUT_TICKS(8)) i_twcb_bank (.core_clk(core_clk), .reset_n(reset_n),
    .address(address), .read(read), .write(write), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .instr_disable(instr_disable), .instr_enable(instr_enable),
    .instr_return(1'b0), .instr_wdog_clr(instr_wdog_clr), .instr_sleep(instr_sleep),
    .irq_taken(irq_taken), .cmp_event(1'b0), .change_event(1'b0), .wdog_osc(wdog_osc),
    .port_in(pins), .port_out(port_out), .port_oe(port_oe), .pulldown_n(pulldown_n),
    .pullhigh_n(pullhigh_n), .opendrain(opendrain), .pwm_out(pwm_out),
    .irq_request(irq_request), .wdog_reset(wdog_reset));
  twcb_core_model i_twcb_core_model (.core_clk(core_clk), .readdata(readdata),
    .waitrequest(waitrequest), .address(address), .read(read), .write(write),
    .writedata(writedata));
  //////////////////////////////////////////////////////////////////////
  initial forever #5 core_clk = ~core_clk;
  always @(posedge core_clk) if (wdog_reset === 1'b1) hits <= hits + 1;
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic rw(input logic wr, input logic [5:0] idx, input logic [7:0] wd);
    i_twcb_core_model.xfer(wr, idx, wd, rd);
  endtask : rw
  // Oscillator edges are spread over several core cycles so the synchroniser sees each one.
  task automatic tick(input int n);
    repeat (n) begin
      wdog_osc <= 1'b1;
      repeat (4) @(posedge core_clk);
      wdog_osc <= 1'b0;
      repeat (4) @(posedge core_clk);
    end
  endtask : tick
  // Each pin level is held four clocks, so no edge falls between two samples.
  task automatic toggle(input int b, input int n);
    repeat (n) begin
      pins[b] <= ~pins[b];
      repeat (4) @(posedge core_clk);
    end
  endtask : toggle
  task automatic summarize;
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : summarize
  initial begin
    repeat (20000) @(posedge core_clk);
    errors++;
    summarize();
  end
  initial begin
    repeat (4) @(posedge core_clk);
    reset_n <= 1'b1;
    foreach (rows[k]) begin
      rw(0, rows[k].i, 8'h00);
      chk(rd, rows[k].r);
      rw(1, rows[k].i, rows[k].w);
      rw(0, rows[k].i, 8'h00);
      chk(rd, rows[k].e);
    end
    @(posedge core_clk);
    chk(port_oe, 8'hA5);
    chk({5'h0, pulldown_n}, 8'h07);
    chk(opendrain, 8'hF7);
    chk(pullhigh_n, 8'hF7);
    // Period 3 and duty 1: high for counts 0 and 1 of every four.
    repeat (40) begin
      @(posedge core_clk);
      hi += pwm_out;
    end
    chk(8'(hi), 8'h14);
    rw(0, 6'h08, 8'h00);
    chk(rd & 8'hFC, 8'h00);
    rw(1, 6'h16, 8'h3C);
    repeat (2) @(posedge core_clk);
    chk(port_out, 8'h3C);
    chk(port_oe, 8'h81);
    rw(1, 6'h16, 8'h00);
    rw(1, 6'h0F, 8'h01);
    rw(1, 6'h1F, 8'h00);
    rw(1, 6'h11, 8'hF0);
    repeat (30) @(posedge core_clk);
    rw(0, 6'h1F, 8'h00);
    chk(rd, 8'h01);
    {instr_enable, instr_disable} <= 2'b11;
    @(posedge core_clk);
    {instr_enable, instr_disable} <= 2'b00;
    repeat (3) @(posedge core_clk);
    chk({7'h0, irq_request}, 8'h01);
    rw(0, 6'h01, 8'h00);
    chk(rd, 8'hC0);
    irq_taken <= 1'b1;
    @(posedge core_clk);
    irq_taken <= 1'b0;
    repeat (3) @(posedge core_clk);
    chk({7'h0, irq_request}, 8'h00);
    {instr_enable, instr_disable} <= 2'b10;
    @(posedge core_clk);
    {instr_enable, instr_disable} <= 2'b01;
    @(posedge core_clk);
    instr_disable <= 1'b0;
    rw(0, 6'h01, 8'h00);
    chk(rd, 8'h80);
    rw(1, 6'h0F, 8'h00);
    rw(0, 6'h1F, 8'h00);
    chk(rd, 8'h00);
    // Two reads 64 cycles apart; the count gained shows the divide ratio.
    for (int c = 0; c < 4; c++) begin
      rw(1, 6'h01, c == 3 ? 8'h80 : 8'h88 | 8'(c));
      rw(0, 6'h11, 8'h00);
      a = rd;
      repeat (61) @(posedge core_clk);
      rw(0, 6'h11, 8'h00);
      chk(rd - a, c == 3 ? 8'd64 : 8'(64 >> (c + 1)));
    end
    rw(1, 6'h01, 8'hA0);
    rw(1, 6'h11, 8'h00);
    toggle(2, 10);
    rw(0, 6'h11, 8'h00);
    chk(rd, 8'h05);
    chk(port_oe, 8'hA1);
    rw(1, 6'h01, 8'hB0);
    rw(1, 6'h11, 8'h00);
    toggle(2, 11);
    rw(0, 6'h11, 8'h00);
    chk(rd, 8'h05);
    toggle(2, 1);
    rw(1, 6'h0E, 8'h80);
    h0 = hits;
    for (int k = 0; k < 4; k++) begin
      tick(4);
      {instr_sleep, instr_wdog_clr} <= k[0] ? 2'b01 : 2'b10;
      @(posedge core_clk);
      {instr_sleep, instr_wdog_clr} <= 2'b00;
    end
    chk(8'(hits - h0), 8'h00);
    tick(12);
    chk({7'h0, hits != h0}, 8'h01);
    rw(1, 6'h0E, 8'hA0);
    instr_wdog_clr <= 1'b1;
    @(posedge core_clk);
    instr_wdog_clr <= 1'b0;
    h0 = hits;
    tick(12);
    chk(8'(hits - h0), 8'h00);
    tick(4);
    chk(8'(hits - h0), 8'h01);
    rw(1, 6'h0E, 8'h00);
    h0 = hits;
    tick(12);
    chk(8'(hits - h0), 8'h00);
    rw(1, 6'h06, 8'h5B);
    rw(1, 6'h0E, 8'h40);
    rw(1, 6'h01, 8'h80);
    rw(1, 6'h0F, 8'h04);
    rw(1, 6'h1F, 8'h00);
    toggle(0, 1);
    rw(0, 6'h1F, 8'h00);
    chk(rd, 8'h00);
    rw(0, 6'h16, 8'h00);
    chk(rd, 8'h01);
    toggle(0, 1);
    rw(0, 6'h1F, 8'h00);
    chk(rd, 8'h04);
    rw(1, 6'h01, 8'h00);
    rw(1, 6'h1F, 8'h00);
    toggle(0, 1);
    rw(0, 6'h1F, 8'h00);
    chk(rd, 8'h04);
    rw(1, 6'h0E, 8'h00);
    rw(1, 6'h1F, 8'h00);
    toggle(0, 2);
    rw(0, 6'h1F, 8'h00);
    chk(rd, 8'h00);
    // Reset in mid-run: outputs fall back at once, registers read their reset values.
    reset_n <= 1'b0;
    @(posedge core_clk);
    chk(port_oe, 8'h00);
    chk({5'h0, pulldown_n}, 8'h07);
    chk(opendrain, 8'h00);
    chk(pullhigh_n, 8'hF7);
    chk({5'h0, irq_request, pwm_out, waitrequest}, 8'h03);
    reset_n <= 1'b1;
    rw(0, 6'h01, 8'h00);
    chk(rd, 8'hBF);
    rw(0, 6'h0E, 8'h00);
    chk(rd, 8'h80);
    summarize();
  end
endmodule : tb
